// >>> bench/ssrg_user_model.sv
// user logic model, clocked by the system clock
// assumes the chip reset and recovery flag of ssrg_top
`timescale 1ns/1ps

module ssrg_user_model import ssrg_pkg::*; (
    // clock
    input  wire logic clk_i,
    // reset state seen by user logic
    input  wire logic usr_rst_n_i,
    input  wire logic clk_ok_i,
    // user data towards the pins
    output ssrg_pins_t data_o
);
    // ------------------------------------------------
    // data source
    // ------------------------------------------------
    integer seed = 34359;    // fixed seed

    initial data_o = 8'h00;

    // new data only once recovery has elapsed
    always @(posedge clk_i) begin
        if (usr_rst_n_i === 1'b1 && clk_ok_i === 1'b1) begin
            data_o <= ssrg_pins_t'($random(seed));
        end else begin
            data_o <= 8'h00;  // held in reset
        end
    end
endmodule : ssrg_user_model

// >>> bench/startup_sync_reset_gen_bench.sv
// self-checking bench of the start-up reset generator
// assumes pull-ups on done and reset lines, one chained peer
`timescale 1ns/1ps

module startup_sync_reset_gen_bench import ssrg_pkg::*;;
    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    logic       MCLK_I, RST_I, CONFIG_CLOCK_I, CFG_DATA_I;
    logic       CFG_PROG_N_I, DONE_O, DONE_OE_O;
    logic       CONFIG_ACTIVE_LOW_PIN_O, RST_LINE_O, RST_LINE_OE_O;
    logic       USR_RST_N_O, USR_CLK_OK_O, peer_oe;
    wire logic  DONE_I, RST_LINE_I;
    ssrg_pins_t USR_D_I, PIN_O, PIN_OE_O, USR_OE_ARM_O, en, ex;
    ssrg_pins_t exp_q[$];        // expected enables at activation
    integer     failures = 0, total_checks = 0, seed = 34359;
    integer     phase = 0, pulses = 0, i;
    logic       act_p = 1'b0, oe_p = 1'b0, ok_p = 1'b0;
    ssrg_pins_t d_p;

    // wired-AND lines with pull-ups
    assign DONE_I     = ~(DONE_OE_O | peer_oe);
    assign RST_LINE_I = ~RST_LINE_OE_O;

    ssrg_top i_ssrg_top (
        .MCLK_I(MCLK_I), .RST_I(RST_I),
        .CONFIG_CLOCK_I(CONFIG_CLOCK_I), .CFG_DATA_I(CFG_DATA_I),
        .CFG_PROG_N_I(CFG_PROG_N_I), .DONE_I(DONE_I),
        .DONE_O(DONE_O), .DONE_OE_O(DONE_OE_O),
        .CONFIG_ACTIVE_LOW_PIN_O(CONFIG_ACTIVE_LOW_PIN_O),
        .RST_LINE_I(RST_LINE_I), .RST_LINE_O(RST_LINE_O),
        .RST_LINE_OE_O(RST_LINE_OE_O), .USR_D_I(USR_D_I),
        .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
        .USR_OE_ARM_O(USR_OE_ARM_O), .USR_RST_N_O(USR_RST_N_O),
        .USR_CLK_OK_O(USR_CLK_OK_O)
    );

    ssrg_user_model i_ssrg_user_model (
        .clk_i(MCLK_I), .usr_rst_n_i(USR_RST_N_O),
        .clk_ok_i(USR_CLK_OK_O), .data_o(USR_D_I)
    );

    // ------------------------------------------------
    // clock
    // ------------------------------------------------
    initial begin
        MCLK_I = 1'b0;
        forever #12.5 MCLK_I = ~MCLK_I;
    end

    // ------------------------------------------------
    // compare tasks and verdict
    // ------------------------------------------------
    task automatic check1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check1

    task automatic check8(input ssrg_pins_t got, input ssrg_pins_t exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check8

    task automatic finish_test;
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // one configuration clock rise, two cycles high, two low
    task automatic cfg_rise(input logic b);
        @(posedge MCLK_I);
        CONFIG_CLOCK_I <= 1'b1;
        CFG_DATA_I     <= b;
        repeat (2) @(posedge MCLK_I);
        CONFIG_CLOCK_I <= 1'b0;
        @(posedge MCLK_I);
        #1;
    endtask : cfg_rise

    // bounded wait for a level, timeout ends the run
    // sel 0 watches the done enable, sel 1 the dedicated pin
    task automatic wait_lvl(input bit sel, input logic v);
        logic s;
        s = sel ? CONFIG_ACTIVE_LOW_PIN_O : DONE_OE_O;
        for (i = 0; i < 20 && s !== v; i++) begin
            @(posedge MCLK_I) #1;
            s = sel ? CONFIG_ACTIVE_LOW_PIN_O : DONE_OE_O;
        end
        if (s !== v) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, s, v);
            finish_test();
        end
    endtask : wait_lvl

    // ------------------------------------------------
    // output monitor: activation and reset pulse
    // ------------------------------------------------
    always @(posedge MCLK_I) begin
        #1;
        if (RST_LINE_OE_O === 1'b1 && oe_p !== 1'b1) pulses++;
        if (act_p === 1'b0 && CONFIG_ACTIVE_LOW_PIN_O === 1'b1) begin
            if (exp_q.size() == 0) failures++;
            else check8(PIN_OE_O, exp_q.pop_front());
            check1(RST_LINE_OE_O, 1'b0);
            phase = 1;
        end else if (phase == 1) begin
            check1(RST_LINE_OE_O, 1'b1);
            check1(USR_RST_N_O, 1'b0);
            phase = 2;
        end else if (phase == 2) begin
            check1(RST_LINE_OE_O, 1'b0);
            check1(USR_RST_N_O, 1'b1);
            check8(PIN_O, 8'h00);
            phase = 3;
        end else if (phase == 3) begin
            check1(USR_CLK_OK_O, 1'b1);
            phase = 0;
        end
        if (ok_p && USR_CLK_OK_O === 1'b1) check8(PIN_O, d_p);
        act_p = CONFIG_ACTIVE_LOW_PIN_O;
        oe_p  = RST_LINE_OE_O;
        ok_p  = (USR_CLK_OK_O === 1'b1);
        d_p   = USR_D_I;
    end

    // ------------------------------------------------
    // main sequence: two configuration rounds
    // ------------------------------------------------
    initial begin
        RST_I = 1'b1;
        CONFIG_CLOCK_I = 1'b0;
        CFG_DATA_I = 1'b0;
        CFG_PROG_N_I = 1'b1;
        peer_oe = 1'b1;
        repeat (2) @(posedge MCLK_I);
        RST_I <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            if (r == 1) begin
                // restart configuration of a running chip
                @(posedge MCLK_I);
                CFG_PROG_N_I <= 1'b0;
                peer_oe      <= 1'b1;
                repeat (2) @(posedge MCLK_I);
                CFG_PROG_N_I <= 1'b1;
            end
            #1;
            check8(PIN_OE_O, 8'h00);
            check1(CONFIG_ACTIVE_LOW_PIN_O, 1'b0);
            check1(RST_LINE_OE_O, 1'b0);
            check1(DONE_OE_O, 1'b1);
            en = (r == 0) ? ssrg_pins_t'($random(seed)) : 8'hFF;
            for (int k = 0; k < 16; k++) begin
                cfg_rise(k < 8 ? en[k] : 1'($random(seed)));
                if (k < 8) check1(USR_OE_ARM_O[k], en[k]);
                check8(PIN_OE_O, 8'h00);
            end
            wait_lvl(1'b0, 1'b0);
            // peer still loading: rises must not activate
            repeat (2) cfg_rise(1'b0);
            check1(CONFIG_ACTIVE_LOW_PIN_O, 1'b0);
            check1(RST_LINE_OE_O, 1'b0);
            check8(PIN_OE_O, 8'h00);
            peer_oe <= 1'b0;
            exp_q.push_back(en);
            pulses = 0;
            cfg_rise(1'b0);
            wait_lvl(1'b1, 1'b1);
            // later rises and idle time bring no second pulse
            repeat (3) cfg_rise(1'b1);
            repeat (20) @(posedge MCLK_I);
            #1;
            check1(pulses == 1, 1'b1);
            check1(CONFIG_ACTIVE_LOW_PIN_O, 1'b1);
        end
        finish_test();
    end
endmodule : startup_sync_reset_gen_bench

// >>> rtl/ssrg_cfg_loader.sv
// configuration bit loader of the start-up reset generator
// assumes the configuration clock is sampled as a plain level
`timescale 1ns/1ps
`include "ssrg_consts.svh"

module ssrg_cfg_loader import ssrg_pkg::*; (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // configuration stream
    input  wire logic       cfg_clk_i,
    input  wire logic       cfg_data_i,
    // results
    output ssrg_pins_t      oe_cfg_o,
    output logic            loaded_o,
    output logic            cfg_rise_o
);

    logic                   cfg_clk_q_ff; // last clock level
    logic [`SSRG_CNT_W-1:0] bit_cnt_ff;   // bits taken so far
    ssrg_pins_t             oe_ff;        // enable bits seen
    logic                   loaded_ff;    // whole frame in
    wire                    take_bit;     // shift one bit
    wire                    is_oe_bit;    // bit lands in oe

    // ------------------------------------------------
    // decode
    // ------------------------------------------------
    assign cfg_rise_o = ssrg_rise(cfg_clk_i, cfg_clk_q_ff);
    assign take_bit   = cfg_rise_o & ~loaded_ff;
    assign is_oe_bit  = bit_cnt_ff < `SSRG_OE_BITS;
    assign oe_cfg_o   = oe_ff;
    assign loaded_o   = loaded_ff;

    // ------------------------------------------------
    // shift in, each bit acts on arrival
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        cfg_clk_q_ff <= cfg_clk_i;
        if (rst_i) begin
            bit_cnt_ff <= `SSRG_CNT_RST;
            oe_ff      <= `SSRG_OE_RST;
            loaded_ff  <= 1'b0;
        end else if (take_bit) begin
            bit_cnt_ff <= bit_cnt_ff + `SSRG_CNT_ONE;
            if (is_oe_bit) begin
                oe_ff[bit_cnt_ff[2:0]] <= cfg_data_i;
            end
            loaded_ff  <= bit_cnt_ff == `SSRG_LAST_BIT;
        end
    end

endmodule : ssrg_cfg_loader

// >>> rtl/ssrg_consts.svh
// constants of the start-up synchronous reset generator
// assumes inclusion by every ssrg design file
`ifndef SSRG_CONSTS_SVH
`define SSRG_CONSTS_SVH

// ------------------------------------------------
// configuration frame
// ------------------------------------------------
`define SSRG_NPINS     8
`define SSRG_CNT_W     5
`define SSRG_LAST_BIT  5'h0F
`define SSRG_OE_BITS   5'h08
`define SSRG_CNT_RST   5'h00
`define SSRG_CNT_ONE   5'h01
`define SSRG_OE_RST    8'h00

// ------------------------------------------------
// timing
// ------------------------------------------------
`define SSRG_CLK_NS    25
`define SSRG_REC_NS    25
`define SSRG_REC_CYC   \
    (((`SSRG_REC_NS) + (`SSRG_CLK_NS) - 1) / (`SSRG_CLK_NS))
`define SSRG_REC_W     2
`define SSRG_REC_RST   2'h0
`define SSRG_REC_ONE   2'h1

`endif

// >>> rtl/ssrg_pkg.sv
// types and helpers of the start-up reset generator
// assumes ssrg_consts.svh is reachable on the include path
`include "ssrg_consts.svh"

package ssrg_pkg;

    // device life cycle
    typedef enum logic [1:0] {
        ST_CONFIG,
        ST_LOADED,
        ST_ACTIVE
    } ssrg_state_e;

    // one bit per user pin
    typedef logic [`SSRG_NPINS-1:0] ssrg_pins_t;

    // rising edge of a sampled level
    function automatic logic ssrg_rise(input logic cur,
                                       input logic prev);
        return cur & ~prev;
    endfunction : ssrg_rise

endpackage : ssrg_pkg

// >>> rtl/ssrg_pulse_gen.sv
// synchronous reset pulse generator, pulse flip-flop plus fired flag
// assumes the reset line is pulled high outside the device
`timescale 1ns/1ps
`include "ssrg_consts.svh"

module ssrg_pulse_gen (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // device state
    input  wire logic busy_i,    // configuration running
    input  wire logic act_i,     // active-low pin level high
    input  wire logic line_i,    // reset line level
    // generator state
    output logic      q_o,
    output logic      fired_o
);

    logic q_ff;     // generator flip-flop
    logic fired_ff; // pulse already issued
    wire  d_in;     // flip-flop input

    // ------------------------------------------------
    // input: forced high while pin is low
    // ------------------------------------------------
    assign d_in    = act_i ? ~(q_ff | fired_ff) : 1'b1;
    assign q_o     = q_ff;
    assign fired_o = fired_ff;

    // ------------------------------------------------
    // flip-flop, cleared by internal and line reset
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || busy_i) begin
            q_ff <= 1'b0;
        end else if (!line_i) begin
            q_ff <= 1'b0;
        end else begin
            q_ff <= d_in;
        end
    end

    // ------------------------------------------------
    // one pulse per configuration
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || busy_i) begin
            fired_ff <= 1'b0;
        end else if (q_ff) begin
            fired_ff <= 1'b1;
        end
    end

endmodule : ssrg_pulse_gen

// >>> rtl/ssrg_top.sv
// start-up and synchronous reset block of a gate array
// assumes a pull-up on the chip reset line and the done line
// assumes all inputs synchronous to MCLK_I
//
// Notes on behaviour
// - configuring: pins tri-stated, flip-flops held reset
// - chained devices go active on one edge
// - go active on rising configuration clock edge
// - enable bits armed as soon as loaded, drive pins once active
// - user flip-flops clock one cycle after reset release
// - configuring: generator input high, output low
// - after config: pin high, generator still low
// - first clock: generator high, drives line low
// - low line resets chip and generator
// - two flip-flops, one pin, dedicated pin
`timescale 1ns/1ps
`include "ssrg_consts.svh"

module ssrg_top import ssrg_pkg::*; (
    // system clock and reset
    input  wire logic MCLK_I,
    input  wire logic RST_I,
    // configuration port
    input  wire logic CONFIG_CLOCK_I,
    input  wire logic CFG_DATA_I,
    input  wire logic CFG_PROG_N_I,
    // shared done line, open drain
    input  wire logic DONE_I,
    output logic      DONE_O,
    output logic      DONE_OE_O,
    // dedicated active-low configuration pin
    output logic      CONFIG_ACTIVE_LOW_PIN_O,
    // chip reset line, open drain
    input  wire logic RST_LINE_I,
    output logic      RST_LINE_O,
    output logic      RST_LINE_OE_O,
    // user pins
    input  ssrg_pins_t USR_D_I,
    output ssrg_pins_t PIN_O,
    output ssrg_pins_t PIN_OE_O,
    output ssrg_pins_t USR_OE_ARM_O,
    // user reset and recovery
    output logic      USR_RST_N_O,
    output logic      USR_CLK_OK_O
);

    // ------------------------------------------------
    // declarations
    // ------------------------------------------------
    ssrg_state_e            state_ff;   // life cycle
    ssrg_state_e            nxt_state;  // next life cycle
    ssrg_pins_t             oe_cfg;     // loaded enables
    ssrg_pins_t             pin_q_ff;   // output data
    logic [`SSRG_REC_W-1:0] rec_cnt_ff; // recovery count
    wire                    loaded;     // frame complete
    wire                    cfg_rise;   // config clock edge
    wire                    cfg_rst;    // restart loader
    wire                    active;     // device running
    wire                    busy;       // still configuring
    wire                    line_low;   // chip reset asserted
    wire                    chip_rst;   // whole-chip reset
    wire                    go;         // become active now
    wire                    gen_q;      // generator output
    wire                    gen_fired;  // pulse done
    wire                    rec_done;   // recovery elapsed

    // ------------------------------------------------
    // decode
    // ------------------------------------------------
    assign cfg_rst  = RST_I | ~CFG_PROG_N_I;
    assign active   = state_ff == ST_ACTIVE;
    assign busy     = ~active;
    assign line_low = ~RST_LINE_I;
    assign chip_rst = busy | line_low;
    assign go       = cfg_rise & DONE_I;
    assign rec_done = rec_cnt_ff ==
                      `SSRG_REC_W'(`SSRG_REC_CYC);

    // ------------------------------------------------
    // configuration loader
    // ------------------------------------------------
    ssrg_cfg_loader u_loader (
        .clk_i      (MCLK_I),
        .rst_i      (cfg_rst),
        .cfg_clk_i  (CONFIG_CLOCK_I),
        .cfg_data_i (CFG_DATA_I),
        .oe_cfg_o   (oe_cfg),
        .loaded_o   (loaded),
        .cfg_rise_o (cfg_rise)
    );

    // ------------------------------------------------
    // life cycle next state
    // ------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            // loading the frame
            ST_CONFIG: begin
                if (loaded) begin
                    nxt_state = ST_LOADED;
                end
            end
            // wait for chain and clock edge
            ST_LOADED: begin
                if (go) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            // running until reprogrammed
            ST_ACTIVE: begin
                nxt_state = ST_ACTIVE;
            end
            // illegal code
            default: begin
                nxt_state = ST_CONFIG;
            end
        endcase
    end

    // ------------------------------------------------
    // life cycle register
    // ------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (cfg_rst) begin
            state_ff <= ST_CONFIG;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------
    // done line: hold low until own frame is in
    // ------------------------------------------------
    assign DONE_O    = 1'b0;
    assign DONE_OE_O = ~loaded & ~active;

    // ------------------------------------------------
    // dedicated pin, low while configuring
    // ------------------------------------------------
    assign CONFIG_ACTIVE_LOW_PIN_O = active;

    // ------------------------------------------------
    // reset pulse generator
    // ------------------------------------------------
    ssrg_pulse_gen u_gen (
        .clk_i   (MCLK_I),
        .rst_i   (cfg_rst),
        .busy_i  (busy),
        .act_i   (CONFIG_ACTIVE_LOW_PIN_O),
        .line_i  (RST_LINE_I),
        .q_o     (gen_q),
        .fired_o (gen_fired)
    );

    // ------------------------------------------------
    // reset line driver: pulls low while high
    // ------------------------------------------------
    assign RST_LINE_O    = 1'b0;
    assign RST_LINE_OE_O = gen_q;

    // ------------------------------------------------
    // user pin data, held reset while chip reset
    // ------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (cfg_rst || chip_rst) begin
            pin_q_ff <= `SSRG_OE_RST;
        end else begin
            pin_q_ff <= USR_D_I;
        end
    end

    // ------------------------------------------------
    // user pin enables
    // ------------------------------------------------
    assign PIN_O        = pin_q_ff;
    assign PIN_OE_O     = active ? oe_cfg
                                 : `SSRG_OE_RST;
    assign USR_OE_ARM_O = oe_cfg;

    // ------------------------------------------------
    // user reset, released on a system clock edge
    // ------------------------------------------------
    assign USR_RST_N_O = ~chip_rst;

    // ------------------------------------------------
    // recovery count after reset release
    // ------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (cfg_rst || chip_rst) begin
            rec_cnt_ff <= `SSRG_REC_RST;
        end else if (!rec_done) begin
            rec_cnt_ff <= rec_cnt_ff + `SSRG_REC_ONE;
        end
    end

    // clock permitted once recovery has elapsed
    assign USR_CLK_OK_O = rec_done;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------

    // activation step
    sequence s_arm;
        $rose(active);
    endsequence

    // generator fires and line follows
    sequence s_fire;
        $rose(RST_LINE_OE_O) ##0 !RST_LINE_I;
    endsequence

    // chip reset line low, from any driver
    sequence s_line_low;
        !RST_LINE_I;
    endsequence

    chk_pins_tristate: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        !active |-> PIN_OE_O == `SSRG_OE_RST)
        else $error("pin driven while configuring");

    chk_ff_held: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        !active |=> pin_q_ff == `SSRG_OE_RST)
        else $error("flip-flop left reset while configuring");

    chk_chain_wait: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        state_ff == ST_LOADED && !DONE_I && CFG_PROG_N_I
        |=> !active)
        else $error("active before chain done");

    chk_go_edge: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_arm |-> $past(cfg_rise) && $past(DONE_I))
        else $error("active without config clock edge");

    chk_oe_early: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_arm |-> PIN_OE_O == $past(USR_OE_ARM_O))
        else $error("enables not ready before activation");

    chk_gen_idle_cfg: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        !active |-> !RST_LINE_OE_O && !gen_fired)
        else $error("generator high while configuring");

    chk_pin_after: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_arm |-> CONFIG_ACTIVE_LOW_PIN_O && !RST_LINE_OE_O)
        else $error("generator high before first clock");

    chk_gen_fires: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_arm ##0 (RST_LINE_I && CFG_PROG_N_I)
        |=> RST_LINE_OE_O)
        else $error("generator missed first clock");

    chk_pulse_short: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_fire |-> !USR_RST_N_O ##1 !RST_LINE_OE_O)
        else $error("reset pulse not ended by line");

    chk_single_pulse: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        $fell(RST_LINE_OE_O) && active && CFG_PROG_N_I
        |=> !RST_LINE_OE_O [*8])
        else $error("second reset pulse");

    chk_rec_wait: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        $rose(USR_RST_N_O) |-> !USR_CLK_OK_O)
        else $error("clock allowed at reset release");

    chk_rec_done: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        $rose(USR_RST_N_O) ##1 USR_RST_N_O
        && CFG_PROG_N_I |-> USR_CLK_OK_O)
        else $error("recovery longer than one cycle");

    // driver lets go once the line has reset the generator
    chk_pulse_one: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        RST_LINE_OE_O |=> !RST_LINE_OE_O)
        else $error("reset pulse longer than one cycle");

    // a low line clears user data and the recovery count
    chk_line_clears: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        s_line_low |=> pin_q_ff == `SSRG_OE_RST && !USR_CLK_OK_O)
        else $error("low reset line did not reset the chip");

    // once fired the generator stays quiet
    chk_fired_idle: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        gen_fired && active |-> !RST_LINE_OE_O)
        else $error("generator fired again after its pulse");

    // a loaded device follows the shared edge
    chk_chain_go: assert property (
        @(posedge MCLK_I) disable iff (RST_I)
        state_ff == ST_LOADED && go && CFG_PROG_N_I |=> active)
        else $error("loaded device missed the shared edge");

endmodule : ssrg_top
